// ---- core/oip_pkg.sv ----
// Purpose: Shared constants and carriers for the multicarrier port sender.
// Assumes: One 40 MHz clock; the link clock is made here by division.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package oip_pkg;

    // Register map
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_GUARD = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // Control fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_MUTE_LSB = 1;
    localparam int CTRL_BYPASS_BIT = 4;
    localparam int CTRL_SIZE8K_BIT = 5;
    localparam int CTRL_W = 6;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // Status fields
    localparam int STAT_UNDERRUN_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 1;
    localparam int STAT_COUNT_LSB = 16;

    // Guard interval and useful length, in samples
    localparam int GUARD_W = 11;
    localparam logic [10:0] GUARD_RESET = 11'h0C0;
    localparam logic [10:0] GUARD_MIN = 11'h0C0;
    localparam logic [10:0] GUARD_MAX = 11'h400;
    localparam int SLOT_W = 14;
    localparam logic [13:0] USEFUL_4K = 14'h1000;
    localparam logic [13:0] USEFUL_8K = 14'h2000;
    localparam logic [10:0] MARKER_SAMPLES = 11'h002;

    // Port geometry
    localparam int CHANNELS = 3;
    localparam int LANE_W = 3;
    localparam int PORT_W = 9;
    localparam int IQ_W = 6;
    localparam int BLI_W = 4;
    localparam int BYP_W = 18;
    localparam logic [1:0] LAST_BEAT = 2'h3;

    // Link timing: one DDR beat of the 409.6 MHz link clock
    localparam int CLK_PS = 25000;
    localparam int BEAT_PS = 1220;
    localparam int BEAT_CYC = (BEAT_PS / CLK_PS) < 1 ? 1 : (BEAT_PS / CLK_PS);

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0] bli;
        logic [5:0] i;
        logic [5:0] q;
    } oip_sample_t;

    typedef struct packed {
        oip_sample_t [2:0] ch;
    } oip_frame_t;

    typedef struct packed {
        logic [17:0] i;
        logic [17:0] q;
    } oip_byp_t;

    typedef struct packed {
        logic run;
        logic [2:0] mute;
        logic bypass;
        logic size8k;
        logic [10:0] guard;
    } oip_cfg_t;

    typedef enum logic [1:0] {SLOT_IDLE, SLOT_MARK, SLOT_DATA} oip_slot_t;

endpackage

// ---- core/oip_beat_timer.sv ----
// Purpose: Beat and link clock edge enables from the system clock.
// Assumes: HALF system cycles per half beat.
// Notes: Clock edges fall mid-beat so the link clock lags data by 90 deg.
`timescale 1ns/1ps
`default_nettype none
module oip_beat_timer #(
    parameter int HALF = oip_pkg::BEAT_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    output logic beat_go,
    output logic edge_go
);
    localparam int CW = $clog2(2 * HALF + 1);
    localparam logic [CW-1:0] LAST = CW'(2 * HALF - 1);
    localparam logic [CW-1:0] MID = CW'(HALF);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;

    if (HALF < 1) begin : g_chk
        $error("oip_beat_timer: HALF must be at least 1");
    end

    assign cnt_next = (cnt_reg == LAST) ? '0 : cnt_reg + CW'(1);
    assign beat_go = (cnt_reg == '0);
    assign edge_go = (cnt_reg == MID);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule
`default_nettype wire

// ---- core/oip_lane_mux.sv ----
// Purpose: Picks one channel's triplet and marker bit for a beat.
// Assumes: Beat 0 is the first beat of a sample.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module oip_lane_mux (
    input wire oip_pkg::oip_sample_t sample,
    input wire logic [1:0] beat,
    input wire oip_pkg::oip_slot_t cls,
    output logic [2:0] lane,
    output logic mark
);
    logic [2:0] triplet;
    logic bli_bit;

    // R4: I high, I low, Q high, Q low
    always_comb begin
        unique case (beat)
            2'h0: triplet = sample.i[5:3];
            2'h1: triplet = sample.i[2:0];
            2'h2: triplet = sample.q[5:3];
            2'h3: triplet = sample.q[2:0];
        endcase
    end

    // R7: loading index MSB first
    assign bli_bit = sample.bli[2'h3 - beat];
    assign lane = (cls == oip_pkg::SLOT_DATA) ? triplet : 3'h0;
    // R6: marker high in last prefix samples
    assign mark = (cls == oip_pkg::SLOT_MARK) ||
                  ((cls == oip_pkg::SLOT_DATA) && bli_bit);
endmodule
`default_nettype wire

// ---- core/oip_port_tx.sv ----
// Purpose: Sender for one multicarrier input port, driving nine DDR data
//   lines, three marker lines and the source clock from a sample stream.
// Assumes: AXI4-Lite slave for control; one frame holds three channels.
// Notes: Config is taken at each symbol start so a symbol never tears.
// Functional notes
// R1: nine DDR lines at fixed sample rate
// R2: lanes 2:0, 5:3, 8:6 per channel
// R3: four beats carry one sample
// R4: beat order I high, I low, Q high, Q low
// R5: device finds boundary after eight high beats
// R6: marker high last two prefix samples
// R7: marker carries loading index MSB first
// R8: device mutes symbol when marker missing
// R9: marker held low mutes whole channel
// R10: unused channel: marker low, data zero
// R11: resume only with fresh marker boundary
// R12: device applies gain from index table
// R13: device expands samples as 2x+L
// R14: software programs n between 0 and 7
// R15: device ignores n for 0, 8, 15
// R16: index 8 marks a pilot subcarrier
// R17: device buffers into sixteen-word FIFO
// R18: device stores one whole symbol
// R19: 4K/8K size, guard 192 to 1024
// R20: only useful slots carry data
// R21: device samples both clock edges
// R22: clock shifted 90 degrees from data
// R23: bypass: 18-bit words, first marker valid
// R24: device pilot sequence from 13-bit register
// R25: pilot level maps bit to plus/minus one
// R26: device resyncs only on fresh marker
`timescale 1ns/1ps
`default_nettype none
module oip_port_tx #(
    parameter int ADDR_W = 4,
    parameter int HALF = oip_pkg::BEAT_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic in_valid,
    output logic in_ready,
    input wire oip_pkg::oip_frame_t in_data,
    output logic source_data_clock,
    output logic [8:0] port_data_lane_pair,
    output logic [2:0] marker_lines
);
    if (ADDR_W < 4) begin : g_chk
        $error("oip_port_tx: ADDR_W must be at least 4");
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = val[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [10:0] clamp_guard(input logic [10:0] g);
        logic [10:0] r;
        r = g;
        if (g < oip_pkg::GUARD_MIN) begin
            r = oip_pkg::GUARD_MIN;
        end else if (g > oip_pkg::GUARD_MAX) begin
            r = oip_pkg::GUARD_MAX;
        end
        return r;
    endfunction

    // Register file
    logic [5:0] ctrl_reg;
    logic [10:0] guard_reg;
    logic underrun_reg;
    logic [15:0] sym_count_reg;
    logic aw_rdy_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic ar_rdy_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;

    wire [3:0] wr_addr = s_axi_awaddr[3:0];
    wire [3:0] rd_addr = s_axi_araddr[3:0];
    wire wr_fire = aw_rdy_reg && s_axi_awvalid && s_axi_wvalid;
    wire rd_fire = ar_rdy_reg && s_axi_arvalid;
    wire wr_hi_zero = (ADDR_W == 4) || (s_axi_awaddr >> 4) == '0;
    wire rd_hi_zero = (ADDR_W == 4) || (s_axi_araddr >> 4) == '0;
    wire wr_ctrl = wr_fire && wr_hi_zero && wr_addr == oip_pkg::ADDR_CTRL;
    wire wr_guard = wr_fire && wr_hi_zero && wr_addr == oip_pkg::ADDR_GUARD;
    wire wr_stat = wr_fire && wr_hi_zero && wr_addr == oip_pkg::ADDR_STATUS;
    wire wr_hit = wr_ctrl || wr_guard || wr_stat;
    wire [31:0] ctrl_new = merge({26'h0, ctrl_reg}, s_axi_wdata, s_axi_wstrb);
    wire [31:0] guard_new = merge({21'h0, guard_reg}, s_axi_wdata,
                                  s_axi_wstrb);
    wire clr_underrun = wr_stat && s_axi_wstrb[0] &&
                        s_axi_wdata[oip_pkg::STAT_UNDERRUN_BIT];
    wire rd_hit = rd_hi_zero && (rd_addr == oip_pkg::ADDR_CTRL ||
                  rd_addr == oip_pkg::ADDR_GUARD ||
                  rd_addr == oip_pkg::ADDR_STATUS);

    logic [31:0] rd_word;
    logic cfg_run;
    always_comb begin
        rd_word = 32'h0;
        if (rd_addr == oip_pkg::ADDR_CTRL) begin
            rd_word[5:0] = ctrl_reg;
        end else if (rd_addr == oip_pkg::ADDR_GUARD) begin
            rd_word[10:0] = guard_reg;
        end else if (rd_addr == oip_pkg::ADDR_STATUS) begin
            rd_word[oip_pkg::STAT_UNDERRUN_BIT] = underrun_reg;
            rd_word[oip_pkg::STAT_ACTIVE_BIT] = cfg_run;
            rd_word[oip_pkg::STAT_COUNT_LSB +: 16] = sym_count_reg;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_rdy_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= oip_pkg::RESP_OKAY;
            ctrl_reg <= oip_pkg::CTRL_RESET;
            guard_reg <= oip_pkg::GUARD_RESET;
        end else begin
            aw_rdy_reg <= s_axi_awvalid && s_axi_wvalid && !aw_rdy_reg &&
                          !bvalid_reg;
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? oip_pkg::RESP_OKAY
                                    : oip_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (wr_ctrl) begin
                ctrl_reg <= ctrl_new[5:0];
            end
            if (wr_guard) begin
                guard_reg <= guard_new[10:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ar_rdy_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= oip_pkg::RESP_OKAY;
            rdata_reg <= 32'h0;
        end else begin
            ar_rdy_reg <= s_axi_arvalid && !ar_rdy_reg && !rvalid_reg;
            if (rd_fire) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_hit ? rd_word : 32'h0;
                rresp_reg <= rd_hit ? oip_pkg::RESP_OKAY
                                    : oip_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_awready = aw_rdy_reg;
    assign s_axi_wready = aw_rdy_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = ar_rdy_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // Link timing
    logic beat_go;
    logic edge_go;

    oip_beat_timer #(.HALF(HALF)) u_timer (
        .clk(clk),
        .arst_n(arst_n),
        .beat_go(beat_go),
        .edge_go(edge_go)
    );

    logic [1:0] beat_reg;
    logic [13:0] slot_reg;
    oip_pkg::oip_cfg_t cfg_reg;
    oip_pkg::oip_slot_t cls_reg;
    oip_pkg::oip_frame_t cur_reg;
    logic starved_reg;
    oip_pkg::oip_frame_t hold_reg;
    logic hold_full_reg;
    logic in_ready_reg;

    assign cfg_run = cfg_reg.run;

    wire oip_pkg::oip_cfg_t cfg_live = {ctrl_reg[oip_pkg::CTRL_RUN_BIT],
        ctrl_reg[oip_pkg::CTRL_MUTE_LSB +: 3],
        ctrl_reg[oip_pkg::CTRL_BYPASS_BIT],
        ctrl_reg[oip_pkg::CTRL_SIZE8K_BIT], clamp_guard(guard_reg)};
    // R19: useful length 4K or 8K
    wire [13:0] sym_last = 14'({3'h0, cfg_reg.guard}) +
        (cfg_reg.size8k ? oip_pkg::USEFUL_8K : oip_pkg::USEFUL_4K) - 14'h1;
    wire [1:0] beat_nxt = beat_reg + 2'h1;
    // R3: new sample every fourth beat
    wire samp_go = beat_go && beat_reg == oip_pkg::LAST_BEAT;
    wire sym_wrap = slot_reg >= sym_last;
    wire sym_go = samp_go && sym_wrap;
    wire [13:0] slot_nxt = sym_wrap ? 14'h0 : slot_reg + 14'h1;
    // R11: changes apply only at a symbol start
    wire oip_pkg::oip_cfg_t cfg_use = sym_go ? cfg_live : cfg_reg;
    wire [13:0] guard_use = 14'({3'h0, cfg_use.guard});
    wire [13:0] mark_from = guard_use -
                            14'({3'h0, oip_pkg::MARKER_SAMPLES});

    // R20: outside bypass, guard slots idle then marker, useful slots carry data
    oip_pkg::oip_slot_t cls_new;
    always_comb begin
        if (!cfg_use.run) begin
            cls_new = oip_pkg::SLOT_IDLE;
        end else if (cfg_use.bypass) begin
            cls_new = oip_pkg::SLOT_DATA;
        end else if (slot_nxt < mark_from) begin
            cls_new = oip_pkg::SLOT_IDLE;
        end else if (slot_nxt < guard_use) begin
            cls_new = oip_pkg::SLOT_MARK;
        end else begin
            cls_new = oip_pkg::SLOT_DATA;
        end
    end

    wire consume = samp_go && cls_new == oip_pkg::SLOT_DATA;
    wire take = in_valid && in_ready_reg;
    wire hold_full_next = take || (hold_full_reg && !consume);
    wire starve_now = consume && !hold_full_reg;
    wire oip_pkg::oip_frame_t samp_new = (consume && hold_full_reg) ?
                                         hold_reg : '0;
    wire oip_pkg::oip_frame_t samp_use = samp_go ? samp_new : cur_reg;
    wire oip_pkg::oip_slot_t cls_use = samp_go ? cls_new : cls_reg;
    wire starved_use = samp_go ? starve_now : starved_reg;

    // R10: outside bypass, muted or starved channel sends marker low, data zero
    logic [2:0] lanes [3];
    logic [2:0] marks;
    for (genvar c = 0; c < oip_pkg::CHANNELS; c++) begin : g_lane
        wire mute_c = cfg_use.mute[c] ||
                      (starved_use && cls_use == oip_pkg::SLOT_DATA);
        oip_lane_mux u_mux (
            .sample(samp_use.ch[c]),
            .beat(beat_nxt),
            .cls(mute_c ? oip_pkg::SLOT_IDLE : cls_use),
            .lane(lanes[c]),
            .mark(marks[c])
        );
    end

    // R23: bypass word over all nine lines, first marker as valid
    wire oip_pkg::oip_byp_t byp = samp_use[35:0];
    logic [8:0] byp_lane;
    always_comb begin
        unique case (beat_nxt)
            2'h0: byp_lane = byp.i[17:9];
            2'h1: byp_lane = byp.i[8:0];
            2'h2: byp_lane = byp.q[17:9];
            2'h3: byp_lane = byp.q[8:0];
        endcase
    end
    wire byp_on = cls_use == oip_pkg::SLOT_DATA && !starved_use &&
                  !cfg_use.mute[0];

    // R2: channel lanes 2:0, 5:3, 8:6
    wire [8:0] port_next = cfg_use.bypass ?
        (byp_on ? byp_lane : 9'h000) : {lanes[2], lanes[1], lanes[0]};
    wire [2:0] mark_next = cfg_use.bypass ? {2'h0, byp_on} : marks;

    logic [8:0] port_reg;
    logic [2:0] mark_reg;
    logic source_data_clock_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            beat_reg <= oip_pkg::LAST_BEAT;
            slot_reg <= 14'h3FFF;
            cfg_reg <= '0;
            cls_reg <= oip_pkg::SLOT_IDLE;
            cur_reg <= '0;
            starved_reg <= 1'b0;
        end else if (beat_go) begin
            beat_reg <= beat_nxt;
            if (samp_go) begin
                slot_reg <= slot_nxt;
                cfg_reg <= cfg_use;
                cls_reg <= cls_new;
                cur_reg <= samp_new;
                starved_reg <= starve_now;
            end
        end
    end

    // One-deep holding stage; ready comes from a flop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_reg <= '0;
            hold_full_reg <= 1'b0;
            in_ready_reg <= 1'b0;
        end else begin
            if (take) begin
                hold_reg <= in_data;
            end
            hold_full_reg <= hold_full_next;
            in_ready_reg <= !hold_full_next;
        end
    end

    // R1: DDR beats, data changes once per beat
    // R22: clock edge mid-beat, quarter period late
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port_reg <= 9'h000;
            mark_reg <= 3'h0;
            source_data_clock_reg <= 1'b0;
        end else begin
            if (beat_go) begin
                port_reg <= port_next;
                mark_reg <= mark_next;
            end
            if (edge_go) begin
                source_data_clock_reg <= !source_data_clock_reg;
            end
        end
    end

    // Underrun sticky: a new event wins over a clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            underrun_reg <= 1'b0;
            sym_count_reg <= 16'h0000;
        end else begin
            underrun_reg <= (beat_go && starve_now) ||
                            (underrun_reg && !clr_underrun);
            if (beat_go && sym_go) begin
                sym_count_reg <= sym_count_reg + 16'h0001;
            end
        end
    end

    assign in_ready = in_ready_reg;
    assign source_data_clock = source_data_clock_reg;
    assign port_data_lane_pair = port_reg;
    assign marker_lines = mark_reg;
endmodule
`default_nettype wire

// ---- tb/oip_port_tx_sva.sv ----
// Purpose: Port-level properties of the multicarrier port sender.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes: Link timing is judged in system clock cycles only.
`timescale 1ns/1ps
`default_nettype none
module oip_port_tx_sva #(
    parameter int HALF = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic source_data_clock,
    input wire logic [8:0] port_data_lane_pair,
    input wire logic [2:0] marker_lines
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [15:0] gap;
    logic seen;
    // First toggle has no reference
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap <= 16'h0000;
            seen <= 1'b0;
        end else if ($changed(source_data_clock)) begin
            gap <= 16'h0000;
            seen <= 1'b1;
        end else begin
            gap <= gap + 16'h0001;
        end
    end
    sequence s_write_taken;
        s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    endsequence
    property p_aw_w_pair;
        s_axi_awready == s_axi_wready;
    endproperty
    a_aw_w_pair: assert property (p_aw_w_pair)
        else $error("aw and w ready differ");
    property p_b_follows;
        s_write_taken |=> s_axi_bvalid && !s_axi_awready;
    endproperty
    a_b_follows: assert property (p_b_follows)
        else $error("write answer late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write answer dropped");
    property p_r_follows;
        s_axi_arready && s_axi_arvalid |=> s_axi_rvalid;
    endproperty
    a_r_follows: assert property (p_r_follows)
        else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read answer dropped");
    property p_sclk_rate;
        seen && $changed(source_data_clock) |-> gap == 16'(2 * HALF - 1);
    endproperty
    a_sclk_rate: assert property (p_sclk_rate)
        else $error("link clock half period wrong");
    property p_data_mid;
        $changed(port_data_lane_pair) |-> !$changed(source_data_clock);
    endproperty
    a_data_mid: assert property (p_data_mid)
        else $error("data moved with clock");
    property p_beat_hold;
        $changed(port_data_lane_pair) |=> $stable(port_data_lane_pair);
    endproperty
    a_beat_hold: assert property (p_beat_hold)
        else $error("data beat too short");
    property p_mark_hold;
        $changed(marker_lines) |=> $stable(marker_lines);
    endproperty
    a_mark_hold: assert property (p_mark_hold)
        else $error("marker beat too short");
    property p_stage_full;
        in_valid && in_ready |=> !in_ready;
    endproperty
    a_stage_full: assert property (p_stage_full)
        else $error("stage took a second frame");
endmodule
`default_nettype wire

// ---- tb/oip_far_model.sv ----
// Purpose: Receiving device model that decodes the port into samples.
// Assumes: Link clock edges are seen by sampling it with clk.
// Notes: Keeps the first sixteen samples of each symbol per channel.
`timescale 1ns/1ps
`default_nettype none
module oip_far_model #(
    parameter int USEFUL = 4096
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic source_data_clock,
    input wire logic [8:0] port_data_lane_pair,
    input wire logic [2:0] marker_lines
);
    oip_pkg::oip_sample_t rx_s [3][16];
    logic [11:0] iqs [3];
    logic [3:0] bls [3];
    int rx_n [3];
    int lock_n [3];
    int hi [3];
    int beat [3];
    logic locked [3];
    logic sclk_q;
    // both link clock edges carry a beat
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q = 1'b0;
            rx_n = '{default: 0};
            lock_n = '{default: 0};
            hi = '{default: 0};
            beat = '{default: 0};
            locked = '{default: 1'b0};
        end else if (source_data_clock !== sclk_q) begin
            sclk_q = source_data_clock;
            for (int c = 0; c < 3; c++) begin
                if (locked[c]) begin
                    // lane, beat order, index MSB first
                    iqs[c] = {iqs[c][8:0], port_data_lane_pair[3*c+:3]};
                    bls[c] = {bls[c][2:0], marker_lines[c]};
                    beat[c]++;
                    if (beat[c] == 4) begin
                        beat[c] = 0;
                        if (rx_n[c] < 16) begin
                            rx_s[c][rx_n[c]] = {bls[c], iqs[c]};
                        end
                        rx_n[c]++;
                        if (rx_n[c] == USEFUL) begin
                            locked[c] = 1'b0;
                        end
                    end
                end else begin
                    // eight high beats define the boundary
                    hi[c] = marker_lines[c] ? hi[c] + 1 : 0;
                    if (hi[c] == 8) begin
                        hi[c] = 0;
                        locked[c] = 1'b1;
                        rx_n[c] = 0;
                        lock_n[c]++;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the multicarrier port sender.
// Assumes: Default guard of 192 and 4K size, so one symbol is long.
// Notes: Config lands at a symbol start; the bench polls for it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int HALF = 1;
    logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, in_valid, in_ready;
    logic source_data_clock;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [8:0] port_data_lane_pair;
    logic [2:0] marker_lines;
    oip_pkg::oip_frame_t in_data, f;
    int errors, n_checks, k;
    oip_port_tx #(.ADDR_W(4), .HALF(HALF)) i_dut (.*);
    oip_far_model #(.USEFUL(4096)) i_far (.*);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        @(posedge clk iff s_axi_awready === 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        @(posedge clk iff s_axi_bvalid === 1'b1);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(posedge clk iff s_axi_arready === 1'b1);
        s_axi_arvalid <= 1'b0;
        @(posedge clk iff s_axi_rvalid === 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] v,
                       input logic [1:0] e);
        rd(a);
        check("read data", d, v);
        check("read resp", 32'(r), 32'(e));
    endtask
    // Stream valid stays up between frames, so no double drive
    task automatic send(input oip_pkg::oip_frame_t v);
        in_data <= v;
        in_valid <= 1'b1;
        @(posedge clk iff in_ready === 1'b1);
    endtask
    function automatic oip_pkg::oip_frame_t frame(input int i);
        oip_pkg::oip_frame_t v;
        for (int c = 0; c < 3; c++) begin
            v.ch[c].bli = 4'((i + c) % 8 + 1);
            v.ch[c].i = 6'(i * 5 + c);
            v.ch[c].q = 6'(63 - i - c);
        end
        return v;
    endfunction
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #(80000 * 25);
        errors++;
        $display("wrong value run time expected end seen watchdog");
        close_out;
    end
    initial begin
        errors = 0;
        n_checks = 0;
        arst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, in_valid} = 4'h0;
        {s_axi_bready, s_axi_rready} = 2'h3;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        s_axi_wstrb = 4'hF;
        in_data = '0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rdc(oip_pkg::ADDR_CTRL, 32'h0, oip_pkg::RESP_OKAY);
        rdc(oip_pkg::ADDR_GUARD, 32'h0C0, oip_pkg::RESP_OKAY);
        rdc(4'hC, 32'h0, oip_pkg::RESP_SLVERR);
        wr(4'hC, 32'hFFFFFFFF);
        check("unmapped write", 32'(r), 32'(oip_pkg::RESP_SLVERR));
        $display("test registers done");
        // Run with the third channel muted, smallest guard
        wr(oip_pkg::ADDR_GUARD, 32'h0C0);
        wr(oip_pkg::ADDR_CTRL, 32'h9);
        rdc(oip_pkg::ADDR_CTRL, 32'h9, oip_pkg::RESP_OKAY);
        do begin
            repeat (50) @(posedge clk);
            rd(oip_pkg::ADDR_STATUS);
        end while (d[1] !== 1'b1);
        for (k = 0; k < 8; k++) begin
            send(frame(k));
        end
        in_valid <= 1'b0;
        @(posedge clk iff i_far.rx_n[0] >= 12);
        for (k = 0; k < 8; k++) begin
            f = frame(k);
            check("ch0 sample", 32'(i_far.rx_s[0][k]), 32'(f.ch[0]));
            check("ch1 sample", 32'(i_far.rx_s[1][k]), 32'(f.ch[1]));
        end
        check("gap sample", 32'(i_far.rx_s[0][8]), 32'h0);
        check("ch0 boundaries", 32'(i_far.lock_n[0]), 32'h1);
        check("muted boundaries", 32'(i_far.lock_n[2]), 32'h0);
        rd(oip_pkg::ADDR_STATUS);
        check("underrun flag", {31'h0, d[0]}, 32'h1);
        $display("test stream done");
        close_out;
    end
endmodule
bind oip_port_tx oip_port_tx_sva #(.HALF(HALF)) i_sva (.*);
`default_nettype wire
